// ---- shared/sbc_mode_map.svh ----
`ifndef SBC_MODE_MAP_SVH
`define SBC_MODE_MAP_SVH

// Register offsets on the plain register port
`define REG_MODE_CTRL     8'h00
`define REG_MODE_STATUS   8'h04

// Mode control register fields
`define CTL_MSF_LO        0
`define CTL_MSF_HI        1
`define CTL_CAN_LP        2
`define CTL_WDSEL         3
`define CTL_LONG_RST      4
`define CTL_CAN_WAKE_EN   5
`define CTL_LOCAL_WAKE_EN 6
`define CTL_RESET_VAL     8'h00

// Status register fields
`define ST_STATE_HI       4
`define ST_LIMP           5
`define ST_WDOG_DIS       6

// Mode select field codes
`define MSF_STANDBY       2'h0
`define MSF_SLEEP         2'h1
`define MSF_NORMAL_NOREG  2'h2
`define MSF_NORMAL_CANREG 2'h3

// Timing
`define CLK_PERIOD_NS     100
`define T_RST_SHORT_US    3600
`define T_RST_LONG_US     20000
`define RST_SHORT_CYC     ((`T_RST_SHORT_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_LONG_CYC      ((`T_RST_LONG_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- shared/sbc_mode_pkg.sv ----
package sbc_mode_pkg;

	typedef enum logic [4:0] {
		ST_OFF     = 5'h01,
		ST_STANDBY = 5'h02,
		ST_NORMAL  = 5'h04,
		ST_SLEEP   = 5'h08,
		ST_OVERTMP = 5'h10
	} state_t;

	typedef enum logic [1:0] {
		XCVR_OFF    = 2'h0,
		XCVR_LOWPWR = 2'h1,
		XCVR_ACTIVE = 2'h2
	} xcvr_t;

	typedef enum logic [1:0] {
		WDOG_OFF     = 2'h0,
		WDOG_TIMEOUT = 2'h1,
		WDOG_WINDOW  = 2'h2
	} wdog_t;

endpackage

// ---- src/sbc_mode_controller.sv ----
// Implementation choices: the placing of the registers and the address-and-strobe port.
`include "sbc_mode_map.svh"

module sbc_mode_controller #(
	parameter int SHORT_RST_CYC = `RST_SHORT_CYC,
	parameter int LONG_RST_CYC  = `RST_LONG_CYC
) (
	input  wire logic       CORE_CLK,
	input  wire logic       RESETN,
	input  wire logic [7:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic      [7:0] RDATA,
	input  wire logic       BAT_POFF_DET,
	input  wire logic       BAT_PON_DET,
	input  wire logic       OT_ACT,
	input  wire logic       OT_REL,
	input  wire logic       CAN_WAKE,
	input  wire logic       LOCAL_WAKE_INPUT_ONE,
	input  wire logic       LOCAL_WAKE_INPUT_TWO,
	input  wire logic       WAKE_PENDING,
	input  wire logic       INTERRUPT_REQUEST_LINE_N,
	input  wire logic       WATCHDOG_DISABLE_PIN,
	input  wire logic       SYSTEM_RESET_LINE_IN_N,
	output logic            SYSTEM_RESET_LINE_OUT_N,
	output logic            SYSTEM_RESET_LINE_OE,
	output logic            MAIN_REGULATOR_EN,
	output logic            CAN_REGULATOR_EN,
	output logic      [1:0] CAN_XCVR_MODE,
	output logic            BUS_HIGHZ,
	output logic      [1:0] WDOG_MODE,
	output logic            LIMP_HOME_N,
	output logic      [4:0] MODE_STATE
);

	sbc_mode_pkg::state_t state_r;
	sbc_mode_pkg::state_t state_nxt;
	logic [1:0]  msf_r;
	logic [1:0]  msf_nxt;
	logic        can_lp_r;
	logic        wdsel_r;
	logic        long_r;
	logic        can_wen_r;
	logic        loc_wen_r;
	logic        limp_r;
	logic        limp_nxt;
	logic [23:0] rst_cnt_r;
	logic [23:0] rst_cnt_nxt;
	logic        start_pulse;
	logic        start_short;
	logic        to_standby;

	// Decode
	wire         mode_wr     = WR && (ADDR == `REG_MODE_CTRL);
	wire         stat_wr     = WR && (ADDR == `REG_MODE_STATUS);
	wire         st_active   = (state_r == sbc_mode_pkg::ST_STANDBY) || (state_r == sbc_mode_pkg::ST_NORMAL);
	wire         sleep_req   = mode_wr && (WDATA[`CTL_MSF_HI:`CTL_MSF_LO] == `MSF_SLEEP) && st_active;
	// sleep entry conditions, using the enables carried by the same write
	wire         sleep_ok    = INTERRUPT_REQUEST_LINE_N && !WAKE_PENDING
				&& (WDATA[`CTL_CAN_WAKE_EN] || WDATA[`CTL_LOCAL_WAKE_EN]);
	wire         wake_ev     = (CAN_WAKE && can_wen_r)
				|| ((LOCAL_WAKE_INPUT_ONE || LOCAL_WAKE_INPUT_TWO) && loc_wen_r);
	// Our own drive reads back low on the pin; only count it as the host's when we are not driving
	wire         host_rst    = !SYSTEM_RESET_LINE_IN_N && !SYSTEM_RESET_LINE_OE;
	wire         st_stby_nxt = (state_nxt == sbc_mode_pkg::ST_STANDBY);
	wire         st_norm_nxt = (state_nxt == sbc_mode_pkg::ST_NORMAL);
	wire         st_slp_nxt  = (state_nxt == sbc_mode_pkg::ST_SLEEP);
	wire         hold_rst    = !(st_stby_nxt || st_norm_nxt);
	wire         can_lp_nxt  = mode_wr ? WDATA[`CTL_CAN_LP] : can_lp_r;
	wire         wdsel_nxt   = mode_wr ? WDATA[`CTL_WDSEL] : wdsel_r;
	wire [23:0]  short_len   = 24'(SHORT_RST_CYC);
	wire [23:0]  long_len    = 24'(LONG_RST_CYC);
	wire [7:0]   mode_rd     = {1'b0, loc_wen_r, can_wen_r, long_r, wdsel_r, can_lp_r, msf_r};
	wire [7:0]   stat_rd     = {1'b0, WATCHDOG_DISABLE_PIN, limp_r, state_r};
	wire [7:0]   rd_sel      = (ADDR == `REG_MODE_CTRL) ? mode_rd :
				(ADDR == `REG_MODE_STATUS) ? stat_rd : 8'h00;

	always_comb begin
		state_nxt   = state_r;
		start_pulse = 1'b0;
		start_short = 1'b0;
		to_standby  = 1'b0;
		case (state_r)
			sbc_mode_pkg::ST_OFF: begin
				if (BAT_PON_DET) begin
					state_nxt   = sbc_mode_pkg::ST_STANDBY;
					start_pulse = 1'b1;
					to_standby  = 1'b1;
				end
			end
			sbc_mode_pkg::ST_STANDBY: begin
				if (OT_ACT) begin
					state_nxt = sbc_mode_pkg::ST_OVERTMP;
				end else if (sleep_req) begin
					if (sleep_ok) begin
						state_nxt = sbc_mode_pkg::ST_SLEEP;
					end else begin
						start_short = 1'b1;
					end
				end else if (msf_r[1]) begin
					state_nxt = sbc_mode_pkg::ST_NORMAL;
				end
			end
			sbc_mode_pkg::ST_NORMAL: begin
				if (OT_ACT) begin
					state_nxt = sbc_mode_pkg::ST_OVERTMP;
				end else if (sleep_req) begin
					if (sleep_ok) begin
						state_nxt = sbc_mode_pkg::ST_SLEEP;
					end else begin
						start_short = 1'b1;
					end
				end else if ((msf_r == `MSF_STANDBY) || host_rst) begin
					state_nxt  = sbc_mode_pkg::ST_STANDBY;
					to_standby = 1'b1;
				end
			end
			sbc_mode_pkg::ST_SLEEP: begin
				if (wake_ev) begin
					state_nxt   = sbc_mode_pkg::ST_STANDBY;
					start_pulse = 1'b1;
					to_standby  = 1'b1;
				end
			end
			sbc_mode_pkg::ST_OVERTMP: begin
				if (OT_REL) begin
					state_nxt   = sbc_mode_pkg::ST_STANDBY;
					start_pulse = 1'b1;
					to_standby  = 1'b1;
				end
			end
			default: begin
				state_nxt = sbc_mode_pkg::ST_OFF;
			end
		endcase
		if (BAT_POFF_DET) begin
			state_nxt   = sbc_mode_pkg::ST_OFF;
			start_pulse = 1'b0;
			start_short = 1'b0;
			to_standby  = 1'b0;
		end
	end

	// mode field cleared on every return to standby
	always_comb begin
		msf_nxt = msf_r;
		if (to_standby) begin
			msf_nxt = `MSF_STANDBY;
		end else if (mode_wr && !(sleep_req && !sleep_ok)) begin
			// A refused sleep request leaves the field as it was
			msf_nxt = WDATA[`CTL_MSF_HI:`CTL_MSF_LO];
		end
	end

	// Reset pulse length counter; a long pulse is only used where the width is configurable
	always_comb begin
		rst_cnt_nxt = rst_cnt_r;
		if (start_short) begin
			rst_cnt_nxt = short_len;
		end else if (start_pulse) begin
			rst_cnt_nxt = long_r ? long_len : short_len;
		end else if (rst_cnt_r != 24'h000000) begin
			rst_cnt_nxt = rst_cnt_r - 24'h000001;
		end
		// Power-off clears the count so the next power-on always starts a full pulse
		if (BAT_POFF_DET) begin
			rst_cnt_nxt = 24'h000000;
		end
	end

	// limp bit set on overtemp entry; set wins over a software clear
	assign limp_nxt = ((state_nxt == sbc_mode_pkg::ST_OVERTMP) && (state_r != sbc_mode_pkg::ST_OVERTMP))
			|| (limp_r && !(stat_wr && WDATA[`ST_LIMP]));

	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			state_r   <= sbc_mode_pkg::ST_OFF;
			msf_r     <= `MSF_STANDBY;
			can_lp_r  <= 1'b0;
			wdsel_r   <= 1'b0;
			long_r    <= 1'b0;
			can_wen_r <= 1'b0;
			loc_wen_r <= 1'b0;
			limp_r    <= 1'b0;
			rst_cnt_r <= 24'h000000;
		end else begin
			state_r   <= state_nxt;
			msf_r     <= msf_nxt;
			can_lp_r  <= can_lp_nxt;
			wdsel_r   <= wdsel_nxt;
			long_r    <= mode_wr ? WDATA[`CTL_LONG_RST] : long_r;
			can_wen_r <= mode_wr ? WDATA[`CTL_CAN_WAKE_EN] : can_wen_r;
			loc_wen_r <= mode_wr ? WDATA[`CTL_LOCAL_WAKE_EN] : loc_wen_r;
			limp_r    <= limp_nxt;
			rst_cnt_r <= rst_cnt_nxt;
		end
	end

	// Outputs are registered from next-state values so they change together with the mode
	logic [1:0] xcvr_nxt;
	logic [1:0] wdog_nxt;

	always_comb begin
		xcvr_nxt = sbc_mode_pkg::XCVR_OFF;
		if (st_norm_nxt) begin
			xcvr_nxt = can_lp_nxt ? sbc_mode_pkg::XCVR_LOWPWR : sbc_mode_pkg::XCVR_ACTIVE;
		end else if (st_stby_nxt || st_slp_nxt) begin
			xcvr_nxt = can_lp_nxt ? sbc_mode_pkg::XCVR_LOWPWR : sbc_mode_pkg::XCVR_OFF;
		end
	end

	always_comb begin
		wdog_nxt = sbc_mode_pkg::WDOG_OFF;
		if (st_norm_nxt) begin
			wdog_nxt = wdsel_nxt ? sbc_mode_pkg::WDOG_TIMEOUT : sbc_mode_pkg::WDOG_WINDOW;
		end else if (st_stby_nxt) begin
			wdog_nxt = wdsel_nxt ? sbc_mode_pkg::WDOG_OFF : sbc_mode_pkg::WDOG_TIMEOUT;
		end
		if (WATCHDOG_DISABLE_PIN) begin
			wdog_nxt = sbc_mode_pkg::WDOG_OFF;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			RDATA                   <= 8'h00;
			SYSTEM_RESET_LINE_OUT_N <= 1'b0;
			SYSTEM_RESET_LINE_OE    <= 1'b1;
			MAIN_REGULATOR_EN       <= 1'b0;
			CAN_REGULATOR_EN        <= 1'b0;
			CAN_XCVR_MODE           <= sbc_mode_pkg::XCVR_OFF;
			BUS_HIGHZ               <= 1'b1;
			WDOG_MODE               <= sbc_mode_pkg::WDOG_OFF;
			LIMP_HOME_N             <= 1'b1;
			MODE_STATE              <= sbc_mode_pkg::ST_OFF;
		end else begin
			RDATA                   <= RD ? rd_sel : 8'h00;
			SYSTEM_RESET_LINE_OUT_N <= 1'b0;
			SYSTEM_RESET_LINE_OE    <= hold_rst || (rst_cnt_nxt != 24'h000000);
			// main regulator on in standby and normal
			MAIN_REGULATOR_EN       <= st_stby_nxt || st_norm_nxt;
			CAN_REGULATOR_EN        <= st_norm_nxt && msf_nxt[0];
			CAN_XCVR_MODE           <= xcvr_nxt;
			// bus floats in off and overtemp
			BUS_HIGHZ               <= (state_nxt == sbc_mode_pkg::ST_OFF)
						|| (state_nxt == sbc_mode_pkg::ST_OVERTMP);
			WDOG_MODE               <= wdog_nxt;
			LIMP_HOME_N             <= !limp_nxt;
			MODE_STATE              <= state_nxt;
		end
	end

	// Checks run on the core clock and stay idle while reset is held
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN);

	wire ot_free = !BAT_POFF_DET && !OT_ACT;

	chk_poff_to_off: assert property (BAT_POFF_DET |=> state_r == sbc_mode_pkg::ST_OFF)
		else $error("power-off did not reach Off");
	chk_off_outputs: assert property (state_r == sbc_mode_pkg::ST_OFF
		|-> !MAIN_REGULATOR_EN && !CAN_REGULATOR_EN && BUS_HIGHZ) else $error("Off outputs wrong");
	chk_pon_pulse: assert property (state_r == sbc_mode_pkg::ST_OFF && BAT_PON_DET && !BAT_POFF_DET
		|=> state_r == sbc_mode_pkg::ST_STANDBY && SYSTEM_RESET_LINE_OE && rst_cnt_r != 24'h000000)
		else $error("power-on entry without reset");
	chk_wake_exit: assert property (state_r == sbc_mode_pkg::ST_SLEEP && wake_ev && !BAT_POFF_DET
		|=> state_r == sbc_mode_pkg::ST_STANDBY && msf_r == `MSF_STANDBY && MAIN_REGULATOR_EN
		&& SYSTEM_RESET_LINE_OE) else $error("wake exit wrong");
	chk_normal_exit: assert property (state_r == sbc_mode_pkg::ST_NORMAL && ot_free && !sleep_req
		&& (msf_r == `MSF_STANDBY || host_rst) |=> state_r == sbc_mode_pkg::ST_STANDBY)
		else $error("normal did not return to standby");
	chk_stby_xcvr: assert property (state_r == sbc_mode_pkg::ST_STANDBY |-> MAIN_REGULATOR_EN
		&& CAN_XCVR_MODE == (can_lp_r ? sbc_mode_pkg::XCVR_LOWPWR : sbc_mode_pkg::XCVR_OFF))
		else $error("standby supply or transceiver wrong");
	chk_stby_wdog: assert property (state_r == sbc_mode_pkg::ST_STANDBY && !$past(WATCHDOG_DISABLE_PIN)
		|-> WDOG_MODE == (wdsel_r ? sbc_mode_pkg::WDOG_OFF : sbc_mode_pkg::WDOG_TIMEOUT))
		else $error("standby watchdog mode wrong");
	chk_enter_normal: assert property (state_r == sbc_mode_pkg::ST_STANDBY && msf_r[1] && ot_free
		&& !sleep_req |=> state_r == sbc_mode_pkg::ST_NORMAL && CAN_REGULATOR_EN == msf_r[0])
		else $error("normal entry wrong");
	chk_norm_xcvr: assert property (state_r == sbc_mode_pkg::ST_NORMAL
		|-> CAN_XCVR_MODE == (can_lp_r ? sbc_mode_pkg::XCVR_LOWPWR : sbc_mode_pkg::XCVR_ACTIVE))
		else $error("normal transceiver wrong");
	chk_sleep_grant: assert property (sleep_req && sleep_ok && ot_free
		|=> state_r == sbc_mode_pkg::ST_SLEEP) else $error("sleep not granted");
	chk_sleep_refuse: assert property (sleep_req && !sleep_ok && ot_free
		|=> state_r == $past(state_r) && rst_cnt_r == short_len && SYSTEM_RESET_LINE_OE)
		else $error("refused sleep wrong");
	chk_sleep_outputs: assert property (state_r == sbc_mode_pkg::ST_SLEEP |-> !MAIN_REGULATOR_EN
		&& !CAN_REGULATOR_EN && WDOG_MODE == sbc_mode_pkg::WDOG_OFF && SYSTEM_RESET_LINE_OE)
		else $error("sleep outputs wrong");
	chk_ot_entry: assert property (st_active && OT_ACT && !BAT_POFF_DET
		|=> state_r == sbc_mode_pkg::ST_OVERTMP && !LIMP_HOME_N && SYSTEM_RESET_LINE_OE
		&& BUS_HIGHZ && !MAIN_REGULATOR_EN && !CAN_REGULATOR_EN) else $error("overtemp entry wrong");
	chk_ot_hold: assert property (state_r == sbc_mode_pkg::ST_OVERTMP && !OT_REL && !BAT_POFF_DET
		|=> state_r == sbc_mode_pkg::ST_OVERTMP) else $error("overtemp left early");
	chk_ot_exit: assert property (state_r == sbc_mode_pkg::ST_OVERTMP && OT_REL && !BAT_POFF_DET
		|=> state_r == sbc_mode_pkg::ST_STANDBY && rst_cnt_r != 24'h000000) else $error("overtemp exit wrong");
	chk_reset_drive: assert property (SYSTEM_RESET_LINE_OE == (!st_active || rst_cnt_r != 24'h000000)
		&& !SYSTEM_RESET_LINE_OUT_N) else $error("reset line drive does not follow mode and pulse");
	chk_wdog_disable: assert property ($past(WATCHDOG_DISABLE_PIN) |-> WDOG_MODE == sbc_mode_pkg::WDOG_OFF)
		else $error("watchdog running while disabled");

	// Registered outputs must mirror the mode they were computed for, one edge after the decision
	chk_main_active: assert property (MAIN_REGULATOR_EN == st_active)
		else $error("main regulator enable does not match mode");
	chk_highz_modes: assert property (BUS_HIGHZ == (state_r == sbc_mode_pkg::ST_OFF
		|| state_r == sbc_mode_pkg::ST_OVERTMP)) else $error("bus float does not match mode");
	chk_canreg_normal: assert property (CAN_REGULATOR_EN
		|-> state_r == sbc_mode_pkg::ST_NORMAL && msf_r[0]) else $error("CAN regulator on outside Normal");
	chk_xcvr_active: assert property (CAN_XCVR_MODE == sbc_mode_pkg::XCVR_ACTIVE
		|-> state_r == sbc_mode_pkg::ST_NORMAL && !can_lp_r) else $error("transceiver active outside Normal");
	chk_stby_hold: assert property (state_r == sbc_mode_pkg::ST_STANDBY && ot_free
		&& !mode_wr && !msf_r[1] |=> state_r == sbc_mode_pkg::ST_STANDBY) else $error("Standby left unasked");
	chk_off_hold: assert property (state_r == sbc_mode_pkg::ST_OFF && !BAT_PON_DET
		|=> state_r == sbc_mode_pkg::ST_OFF) else $error("Off left without power-on");
	chk_sleep_hold: assert property (state_r == sbc_mode_pkg::ST_SLEEP && !wake_ev && !BAT_POFF_DET
		|=> state_r == sbc_mode_pkg::ST_SLEEP) else $error("Sleep left without wake-up");
	chk_refuse_field: assert property (sleep_req && !sleep_ok && ot_free
		|=> msf_r == $past(msf_r)) else $error("refused sleep changed mode field");
	// A software clear must not beat the overtemp set, so the clear check excludes activation
	chk_limp_hold: assert property (limp_r && !(stat_wr && WDATA[`ST_LIMP])
		|=> !LIMP_HOME_N) else $error("limp output released without clear");
	chk_limp_clear: assert property (stat_wr && WDATA[`ST_LIMP] && !OT_ACT
		|=> LIMP_HOME_N) else $error("limp clear ignored");
	chk_norm_wdog: assert property (state_r == sbc_mode_pkg::ST_NORMAL && !$past(WATCHDOG_DISABLE_PIN)
		|-> WDOG_MODE == (wdsel_r ? sbc_mode_pkg::WDOG_TIMEOUT : sbc_mode_pkg::WDOG_WINDOW))
		else $error("normal watchdog mode wrong");
	chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
		else $error("read data outside the answer cycle");

	cov_sleep: cover property (state_r == sbc_mode_pkg::ST_NORMAL ##1 state_r == sbc_mode_pkg::ST_SLEEP);
	cov_refuse: cover property (sleep_req && !sleep_ok);
	cov_ot_cycle: cover property (state_r == sbc_mode_pkg::ST_OVERTMP ##1 state_r == sbc_mode_pkg::ST_STANDBY);
	cov_wake: cover property (state_r == sbc_mode_pkg::ST_SLEEP ##1 state_r == sbc_mode_pkg::ST_STANDBY);
	cov_limp_clear: cover property (limp_r ##1 !limp_r);

endmodule

// ---- testbench/sbc_host_model.sv ----
module sbc_host_model (
	input  wire logic dev_oe,
	input  wire logic dev_out_n,
	input  wire logic host_rst,
	input  wire logic irq_pend,
	output logic      line_n,
	output logic      int_n
);
	timeunit 1ns;
	timeprecision 1ns;
	// Wired reset line
	// Pulled up, so the line is high unless the device or the host pulls it down
	assign line_n = ~(dev_oe & ~dev_out_n) & ~host_rst;
	assign int_n = ~irq_pend;
endmodule

// ---- testbench/sbc_mode_controller_tb.sv ----
`include "sbc_mode_map.svh"

module sbc_mode_controller_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SH = 8;
	localparam int LG = 16;
	logic       clk = 0, system_reset_line = 0, wr = 0, rd = 0, wpend = 0, irq = 0, wdis = 0, host_rst = 0;
	logic       poff = 0, pon = 0, ot_act = 0, ot_rel = 0, cwake = 0, lw1 = 0, lw2 = 0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rv;
	logic       oe, outn, mreg, creg, hz, limp_n, line_n, int_n;
	logic [1:0] xcvr, wdog;
	logic [4:0] st;
	int         miscompares = 0, n_checks = 0;

	always #50 clk = ~clk;

	sbc_host_model host (.dev_oe(oe), .dev_out_n(outn), .host_rst(host_rst), .irq_pend(irq),
		.line_n(line_n), .int_n(int_n));

	sbc_mode_controller #(.SHORT_RST_CYC(SH), .LONG_RST_CYC(LG)) uut (.CORE_CLK(clk), .RESETN(system_reset_line),
		.ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .BAT_POFF_DET(poff),
		.BAT_PON_DET(pon), .OT_ACT(ot_act), .OT_REL(ot_rel), .CAN_WAKE(cwake),
		.LOCAL_WAKE_INPUT_ONE(lw1), .LOCAL_WAKE_INPUT_TWO(lw2), .WAKE_PENDING(wpend),
		.INTERRUPT_REQUEST_LINE_N(int_n), .WATCHDOG_DISABLE_PIN(wdis), .SYSTEM_RESET_LINE_IN_N(line_n),
		.SYSTEM_RESET_LINE_OUT_N(outn), .SYSTEM_RESET_LINE_OE(oe), .MAIN_REGULATOR_EN(mreg),
		.CAN_REGULATOR_EN(creg), .CAN_XCVR_MODE(xcvr), .BUS_HIGHZ(hz), .WDOG_MODE(wdog),
		.LIMP_HOME_N(limp_n), .MODE_STATE(st));

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask

	task automatic rreg(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		rv = rdata;
		cyc(1);
		chk("read data stands one cycle", rdata, 8'h00);
	endtask

	// Events ordered as poff, pon, ot_act, ot_rel, can wake, local one, local two
	task automatic ev(input logic [6:0] m);
		@(posedge clk);
		{poff, pon, ot_act, ot_rel, cwake, lw1, lw2} <= m;
		@(posedge clk);
		{poff, pon, ot_act, ot_rel, cwake, lw1, lw2} <= 7'h00;
		#1;
	endtask

	// Counts reset-line drive cycles from the first Standby cycle with the line pulled
	task automatic pulse(input int exp);
		int k;
		int n;
		k = 0;
		n = 0;
		while (!(st === sbc_mode_pkg::ST_STANDBY && oe === 1'b1) && k < 50) begin
			cyc(1);
			k++;
		end
		while (oe === 1'b1 && n < LG + 10) begin
			n++;
			cyc(1);
		end
		chk("reset pulse cycles", 8'(n), 8'(exp));
		chk("state after pulse", 8'(st), 8'(sbc_mode_pkg::ST_STANDBY));
	endtask

	task automatic t_power_on;
		chk("off state", 8'(st), 8'(sbc_mode_pkg::ST_OFF));
		chk("off bus float", 8'(hz), 8'h01);
		ev(7'h20);
		pulse(SH);
		chk("standby main reg", 8'(mreg), 8'h01);
		chk("standby xcvr off", 8'(xcvr), 8'(sbc_mode_pkg::XCVR_OFF));
		wreg(`REG_MODE_CTRL, 8'h04);
		cyc(2);
		chk("standby xcvr lowpwr", 8'(xcvr), 8'(sbc_mode_pkg::XCVR_LOWPWR));
		chk("standby wdog timeout", 8'(wdog), 8'(sbc_mode_pkg::WDOG_TIMEOUT));
		wreg(`REG_MODE_CTRL, 8'h0c);
		cyc(2);
		chk("standby wdog off", 8'(wdog), 8'(sbc_mode_pkg::WDOG_OFF));
		wreg(`REG_MODE_CTRL, 8'h04);
		@(posedge clk);
		wdis <= 1'b1;
		cyc(3);
		chk("wdog pin off", 8'(wdog), 8'(sbc_mode_pkg::WDOG_OFF));
		@(posedge clk);
		wdis <= 1'b0;
		rreg(8'h40);
		chk("unmapped read", rv, 8'h00);
		$display("test power_on done");
	endtask

	task automatic t_normal;
		wreg(`REG_MODE_CTRL, 8'h03);
		cyc(2);
		chk("normal state", 8'(st), 8'(sbc_mode_pkg::ST_NORMAL));
		chk("normal can reg on", 8'(creg), 8'h01);
		chk("normal xcvr active", 8'(xcvr), 8'(sbc_mode_pkg::XCVR_ACTIVE));
		chk("normal wdog window", 8'(wdog), 8'(sbc_mode_pkg::WDOG_WINDOW));
		wreg(`REG_MODE_CTRL, 8'h0e);
		cyc(2);
		chk("normal can reg off", 8'(creg), 8'h00);
		chk("normal xcvr lowpwr", 8'(xcvr), 8'(sbc_mode_pkg::XCVR_LOWPWR));
		chk("normal wdog timeout", 8'(wdog), 8'(sbc_mode_pkg::WDOG_TIMEOUT));
		wreg(`REG_MODE_CTRL, 8'h00);
		cyc(2);
		chk("field 00 to standby", 8'(st), 8'(sbc_mode_pkg::ST_STANDBY));
		wreg(`REG_MODE_CTRL, 8'h02);
		cyc(2);
		@(posedge clk);
		host_rst <= 1'b1;
		@(posedge clk);
		host_rst <= 1'b0;
		cyc(2);
		chk("host reset to standby", 8'(st), 8'(sbc_mode_pkg::ST_STANDBY));
		rreg(`REG_MODE_CTRL);
		chk("host reset field", 8'(rv[1:0]), 8'h00);
		$display("test normal done");
	endtask

	task automatic t_refuse;
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			irq <= (i == 1);
			wpend <= (i == 2);
			wreg(`REG_MODE_CTRL, (i == 0) ? 8'h01 : 8'h21);
			pulse(SH);
			chk("refused sleep state", 8'(st), 8'(sbc_mode_pkg::ST_STANDBY));
		end
		@(posedge clk);
		irq <= 1'b0;
		wpend <= 1'b0;
		$display("test refuse done");
	endtask

	task automatic t_sleep;
		for (int i = 0; i < 3; i++) begin
			wreg(`REG_MODE_CTRL, (i == 1) ? 8'h65 : 8'h61);
			cyc(2);
			chk("sleep state", 8'(st), 8'(sbc_mode_pkg::ST_SLEEP));
			chk("sleep regs", {6'h00, mreg, creg}, 8'h00);
			chk("sleep wdog", 8'(wdog), 8'(sbc_mode_pkg::WDOG_OFF));
			chk("sleep reset low", 8'(line_n), 8'h00);
			chk("sleep xcvr", 8'(xcvr), (i == 1) ? 8'h01 : 8'h00);
			ev(7'h04 >> i);
			pulse(SH);
			chk("wake main reg", 8'(mreg), 8'h01);
			rreg(`REG_MODE_CTRL);
			chk("wake field", 8'(rv[1:0]), 8'h00);
		end
		$display("test sleep done");
	endtask

	task automatic t_overtemp;
		wreg(`REG_MODE_CTRL, 8'h10);
		ev(7'h10);
		cyc(1);
		chk("overtemp state", 8'(st), 8'(sbc_mode_pkg::ST_OVERTMP));
		chk("overtemp outs", {4'h0, hz, limp_n, mreg, line_n}, 8'h08);
		cyc(5);
		chk("overtemp held", 8'(st), 8'(sbc_mode_pkg::ST_OVERTMP));
		rreg(`REG_MODE_STATUS);
		chk("status limp and mode", rv, 8'h30);
		ev(7'h08);
		pulse(LG);
		chk("limp kept after exit", 8'(limp_n), 8'h00);
		wreg(`REG_MODE_STATUS, 8'h20);
		chk("limp cleared", 8'(limp_n), 8'h01);
		wreg(`REG_MODE_CTRL, 8'h02);
		cyc(2);
		ev(7'h50);
		cyc(1);
		chk("poff wins", 8'(st), 8'(sbc_mode_pkg::ST_OFF));
		chk("off regs", {6'h00, mreg, hz}, 8'h01);
		$display("test overtemp done");
	endtask

	task automatic end_sim;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge clk);
		system_reset_line <= 1'b1;
		cyc(1);
		t_power_on;
		t_normal;
		t_refuse;
		t_sleep;
		t_overtemp;
		end_sim;
	end

	// The whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		end_sim;
	end
endmodule
